// file: dv/ssc_host_model.sv
/*
  host-side write data driver for the sram core: hands each write's data
  to the pins on the taken edge where the core expects it.
  assumes wr_go and wr_data change at the falling edge with their command.
*/
`timescale 1ns/1ns
module ssc_host_model #(
  parameter int DW = ssc_pkg::LANES*ssc_pkg::LANE_W
) (
  // clock and mode
  input  wire logic          core_clk,
  input  wire logic          clk_gate_n,
  input  wire logic          flow,
  // write cycle from the bench
  input  wire logic          wr_go,
  input  wire logic [DW-1:0] wr_data,
  // data pins toward the core
  output logic      [DW-1:0] dq_i
);
  logic          v0 = 1'b0;
  logic          v1 = 1'b0;
  logic [DW-1:0] d0;
  logic [DW-1:0] d1;

  initial dq_i = '0;

  // count taken edges until a write's data is due, stalls hold it
  always @(posedge core_clk) if (!clk_gate_n) begin
    v0 <= flow ? wr_go : v1;
    d0 <= flow ? wr_data : d1;
    v1 <= !flow && wr_go;
    d1 <= wr_data;
  end

  // due data on the pins, otherwise a pattern that flips every cycle
  always @(negedge core_clk) dq_i <= v0 ? d0 : ~dq_i;
endmodule

// file: dv/tb.sv
/*
  self-checking bench for the sram core: command tasks, a reference
  memory and a two-slot expectation pipe that follows taken edges.
  assumes the host model supplies write data; all pins change at negedge.
*/
`timescale 1ns/1ns
module tb;
  localparam int DW = ssc_pkg::LANES*ssc_pkg::LANE_W;
  localparam int AW = ssc_pkg::ADDR_W_DEF;
  logic          core_clk = 1'b0;
  logic          nrst = 1'b0;
  logic [AW-1:0] addr = '0;
  logic          count_or_load = 1'b0;
  logic          wr_n = 1'b1;
  logic          clk_gate_n = 1'b0;
  logic [2:0]    cs = 3'h5;
  logic [3:0]    ln = 4'hf;
  logic          out_en_n = 1'b0;
  logic          sleep_request = 1'b0;
  logic          burst_order_select = 1'b0;
  logic          flowthru_select_n = 1'b1;
  logic [DW-1:0] dq_i, dq_o, wr_data = '0, n_d, mem [0:(1<<AW)-1];
  logic          dq_oe, sleep_state, flow = 1'b0, quiet = 1'b0, wr_go = 1'b0;
  logic [AW-1:0] base;
  logic [1:0]    step, kind = 2'h0;
  logic          n_v = 1'b0, n_oe = 1'b0;
  logic          e_v [2] = '{1'b0, 1'b0};
  logic          e_oe [2];
  logic [DW-1:0] e_d [2];
  int            fail_count = 0, tests_run = 0, t_in, t_out;

  ssc_sram_ctl #(.ADDR_W(AW)) dut_u (
    .core_clk, .nrst, .addr, .count_or_load, .wr_n, .clk_gate_n,
    .chip_sel_low_first(cs[2]), .chip_sel_high(cs[1]), .chip_sel_low_third(cs[0]),
    .lane_one_wr_n(ln[0]), .lane_two_wr_n(ln[1]),
    .lane_three_wr_n(ln[2]), .lane_four_wr_n(ln[3]),
    .out_en_n, .sleep_request, .burst_order_select, .flowthru_select_n,
    .dq_i, .dq_o, .dq_oe, .sleep_state
  );
  ssc_host_model #(.DW(DW)) host_u (
    .core_clk, .clk_gate_n, .flow, .wr_go, .wr_data, .dq_i
  );

  // 125 MHz clock
  always #4 core_clk = ~core_clk;

  task automatic chk(input string nm, input logic [DW-1:0] seen, input logic [DW-1:0] exp);
    tests_run++;
    if (seen !== exp) begin
      fail_count++;
      $display("Error %s expected %h seen %h", nm, exp, seen);
    end
  endtask

  task automatic close_out;
    $display("checks %0d mismatches %0d", tests_run, fail_count);
    if (fail_count == 0 && tests_run > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask

  function automatic logic [DW-1:0] pat(input logic [AW-1:0] a);
    return DW'({3{a}}) ^ DW'(36'h5a5a5a5a5);
  endfunction

  // one command cycle; tracks the burst and the reference memory
  task automatic op(input logic ld, input logic w, input logic [2:0] c,
                    input logic [AW-1:0] a, input logic [3:0] l, input logic [DW-1:0] d);
    logic [AW-1:0] ea;
    @(negedge core_clk);
    clk_gate_n = 1'b0;
    count_or_load = ld;
    wr_n = !w;
    cs = c;
    addr = a;
    ln = l;
    n_v = !quiet;
    wr_go = 1'b0;
    wr_data = d;
    if (!ld) begin
      kind = (c != 3'h2) ? 2'h0 : w ? 2'h2 : 2'h1;
      base = a;
      step = 2'h0;
    end else step = step + 2'h1;
    ea = {base[AW-1:2], burst_order_select ? base[1:0] ^ step : base[1:0] + step};
    n_oe = kind == 2'h1 && !out_en_n;
    n_d = mem[ea];
    if (kind == 2'h2 && !quiet) begin
      wr_go = 1'b1;
      for (int i = 0; i < ssc_pkg::LANES; i++)
        if (!l[i]) mem[ea][i*ssc_pkg::LANE_W +: ssc_pkg::LANE_W] = d[i*ssc_pkg::LANE_W +: ssc_pkg::LANE_W];
    end
  endtask

  task automatic idle(input int n);
    repeat (n) op(1'b0, 1'b0, 3'h5, '0, 4'hf, '0);
  endtask

  // gated edges carrying a write that must be ignored
  task automatic stall(input int n);
    repeat (n) begin
      @(negedge core_clk);
      clk_gate_n = 1'b1;
      count_or_load = 1'b0;
      cs = 3'h2;
      wr_n = 1'b0;
      ln = 4'h0;
      addr = 12'h104;
    end
  endtask

  // move expectations along on every taken edge while quiet is low
  always @(posedge core_clk) if (!clk_gate_n && !quiet) begin
    e_v[0] <= flow ? n_v : e_v[1];
    e_oe[0] <= flow ? n_oe : e_oe[1];
    e_d[0] <= flow ? n_d : e_d[1];
    e_v[1] <= !flow && n_v;
    e_oe[1] <= n_oe;
    e_d[1] <= n_d;
  end

  // compare the bus once outputs have settled
  always @(negedge core_clk) if (e_v[0] && !quiet) begin
    chk("drive", DW'(dq_oe), DW'(e_oe[0]));
    if (e_oe[0]) chk("read data", dq_o, e_d[0]);
  end

  // watchdog
  initial begin
    #20000;
    fail_count++;
    close_out;
  end

  // main sequence
  initial begin
    repeat (5) @(posedge core_clk);
    chk("drive in reset", DW'(dq_oe), '0);
    @(negedge core_clk) nrst = 1'b1;
    idle(4);
    chk("drive after reset", DW'(dq_oe), '0);
    // pipeline burst write; continues carry stray selects and strobe
    op(1'b0, 1'b1, 3'h2, 12'h106, 4'h0, pat(12'h106));
    for (int i = 1; i < 4; i++)
      op(1'b1, 1'b0, 3'h5, 12'hfff, 4'h0, pat(12'h104 + 12'((i + 2) % 4)));
    op(1'b0, 1'b1, 3'h2, 12'h200, 4'h0, pat(12'h200));
    op(1'b0, 1'b1, 3'h2, 12'h200, 4'h5, ~pat(12'h200));
    op(1'b0, 1'b1, 3'h2, 12'h104, 4'hf, '0);
    idle(2);
    // five-beat read burst wraps to its first address
    op(1'b0, 1'b0, 3'h2, 12'h105, 4'hf, '0);
    for (int i = 0; i < 4; i++) op(1'b1, 1'b1, 3'h0, '0, 4'h0, '0);
    op(1'b0, 1'b0, 3'h2, 12'h200, 4'hf, '0);
    // each inactive select deselects, and so does the continue after it
    for (int i = 0; i < 3; i++) begin
      op(1'b0, 1'b0, 3'h2 ^ (3'h1 << i), 12'h104, 4'hf, '0);
      op(1'b1, 1'b0, 3'h2, 12'h104, 4'hf, '0);
    end
    // read, write, read with no dead cycle
    op(1'b0, 1'b0, 3'h2, 12'h104, 4'hf, '0);
    op(1'b0, 1'b1, 3'h2, 12'h300, 4'h0, pat(12'h300));
    op(1'b0, 1'b0, 3'h2, 12'h105, 4'hf, '0);
    // stalls hold a read on the bus and keep a write off it
    op(1'b0, 1'b0, 3'h2, 12'h106, 4'hf, '0);
    stall(3);
    op(1'b0, 1'b1, 3'h2, 12'h301, 4'h0, pat(12'h301));
    stall(3);
    idle(2);
    op(1'b0, 1'b0, 3'h2, 12'h300, 4'hf, '0);
    op(1'b0, 1'b0, 3'h2, 12'h301, 4'hf, '0);
    op(1'b0, 1'b0, 3'h2, 12'h104, 4'hf, '0);
    // output enable off makes a read a no-op
    out_en_n = 1'b1;
    idle(5);
    op(1'b0, 1'b0, 3'h2, 12'h104, 4'hf, '0);
    out_en_n = 1'b0;
    idle(5);
    // sleep entry and exit take equal time; commands are ignored
    quiet = 1'b1;
    sleep_request = 1'b1;
    t_in = 0;
    while (sleep_state !== 1'b1 && t_in < 20) begin idle(1); t_in++; end
    chk("asleep", DW'(sleep_state), DW'(1'b1));
    op(1'b0, 1'b1, 3'h2, 12'h104, 4'h0, '1);
    chk("asleep drive", DW'(dq_oe), '0);
    sleep_request = 1'b0;
    t_out = 0;
    while (sleep_state !== 1'b0 && t_out < 20) begin idle(1); t_out++; end
    chk("wake delay", DW'(t_out), DW'(t_in));
    idle(2);
    quiet = 1'b0;
    idle(2);
    op(1'b0, 1'b0, 3'h2, 12'h104, 4'hf, '0);
    // flow-through with interleaved bursts
    flowthru_select_n = 1'b0;
    burst_order_select = 1'b1;
    idle(6);
    flow = 1'b1;
    idle(2);
    op(1'b0, 1'b1, 3'h2, 12'h401, 4'h0, pat(12'h401));
    for (int i = 1; i < 4; i++)
      op(1'b1, 1'b1, 3'h0, '0, 4'h0, pat(12'h400 | 12'(1 ^ i)));
    idle(1);
    op(1'b0, 1'b0, 3'h2, 12'h402, 4'hf, '0);
    for (int i = 0; i < 4; i++) op(1'b1, 1'b0, 3'h5, '0, 4'hf, '0);
    op(1'b0, 1'b0, 3'h2, 12'h400, 4'hf, '0);
    op(1'b0, 1'b1, 3'h2, 12'h500, 4'h0, pat(12'h500));
    op(1'b0, 1'b0, 3'h2, 12'h401, 4'hf, '0);
    idle(1);
    op(1'b0, 1'b0, 3'h2, 12'h500, 4'hf, '0);
    idle(3);
    close_out;
  end
endmodule

// file: rtl/ssc_pkg.sv
/*
  shared constants for the synchronous sram read/write control core:
  lane layout, sleep timing, burst order codes and command encodings.
  assumes every user writes names as ssc_pkg::name, with no import.
*/
package ssc_pkg;

  // data bus layout: four byte lanes of nine bits
  localparam int LANES      = 4;
  localparam int LANE_W     = 9;
  localparam int ADDR_W_DEF = 12;
  localparam int CNT_W      = 2;

  // sleep entry and wake-up delays in clock cycles
  localparam logic [1:0] SLEEP_ENTRY_CYC = 2'h2;
  localparam logic [1:0] SLEEP_EXIT_CYC  = 2'h2;

  // burst order select level for a linear sequence
  localparam logic ORDER_LINEAR = 1'b0;

  // reset value of the filtered asynchronous inputs, in the bit order
  // {output enable n, sleep request, burst order, flow-through select n}
  localparam logic [3:0] ASYNC_RST = 4'h9;

  // operation carried by a cycle
  typedef enum logic [2:0] {
    OP_DESEL = 3'h1,
    OP_READ  = 3'h2,
    OP_WRITE = 3'h4
  } ssc_op_e;

endpackage

// file: rtl/ssc_sram_ctl.sv
/*
  synchronous no-turnaround sram core: command decode, burst counter,
  pipeline and flow-through read/write data paths, stall and sleep.
  assumes the host drives the synchronous inputs from logic on core_clk;
  output enable, burst order, sleep and mode pins may be asynchronous.
*/
`timescale 1ns/1ns
module ssc_sram_ctl #(
  parameter int ADDR_W = ssc_pkg::ADDR_W_DEF
) (
  // clock and reset
  input  wire logic                                   core_clk,
  input  wire logic                                   nrst,
  // synchronous command inputs
  input  wire logic [ADDR_W-1:0]                      addr,
  input  wire logic                                   count_or_load,
  input  wire logic                                   chip_sel_low_first,
  input  wire logic                                   chip_sel_high,
  input  wire logic                                   chip_sel_low_third,
  input  wire logic                                   wr_n,
  input  wire logic                                   lane_one_wr_n,
  input  wire logic                                   lane_two_wr_n,
  input  wire logic                                   lane_three_wr_n,
  input  wire logic                                   lane_four_wr_n,
  input  wire logic                                   clk_gate_n,
  // asynchronous control inputs
  input  wire logic                                   out_en_n,
  input  wire logic                                   sleep_request,
  input  wire logic                                   burst_order_select,
  input  wire logic                                   flowthru_select_n,
  // data pins
  input  wire logic [ssc_pkg::LANES*ssc_pkg::LANE_W-1:0] dq_i,
  output logic      [ssc_pkg::LANES*ssc_pkg::LANE_W-1:0] dq_o,
  output logic                                        dq_oe,
  // status
  output logic                                        sleep_state
);

  localparam int DATA_W = ssc_pkg::LANES * ssc_pkg::LANE_W;
  localparam int DEPTH  = 2 ** ADDR_W;

  typedef struct packed {
    ssc_pkg::ssc_op_e             last_op;
    logic [ADDR_W-3:0]            hi;
    logic [ssc_pkg::CNT_W-1:0]    base;
    logic [ssc_pkg::CNT_W-1:0]    cnt;
    ssc_pkg::ssc_op_e             s1_op;
    logic [ADDR_W-1:0]            s1_addr;
    logic [ssc_pkg::LANES-1:0]    s1_be;
    ssc_pkg::ssc_op_e             s2_op;
    logic [ADDR_W-1:0]            s2_addr;
    logic [ssc_pkg::LANES-1:0]    s2_be;
    logic [DATA_W-1:0]            dq_o;
    logic                         drive;
    logic                         oe;
    logic [1:0]                   scnt;
    logic                         asleep;
  } ssc_state_s;

  localparam ssc_state_s ST_RST = '{
    last_op: ssc_pkg::OP_DESEL,
    s1_op:   ssc_pkg::OP_DESEL,
    s2_op:   ssc_pkg::OP_DESEL,
    default: '0
  };

  // low two address bits of a burst step, linear or interleaved
  function automatic logic [1:0] burst_low(input logic [1:0] base,
                                           input logic [1:0] step,
                                           input logic       order);
    if (order == ssc_pkg::ORDER_LINEAR) begin
      burst_low = 2'(base + step);
    end else begin
      burst_low = base ^ step;
    end
  endfunction

  ssc_state_s                q;
  ssc_state_s                n;
  logic [DATA_W-1:0]         mem_q [0:DEPTH-1];
  logic [3:0]                async_s;
  logic                      g_n_s;
  logic                      slp_s;
  logic                      order_s;
  logic                      ft_s;
  logic                      sel;
  logic                      go;
  logic [1:0]                nxt_cnt;
  logic [ssc_pkg::LANES-1:0] be_now;
  ssc_pkg::ssc_op_e          cur_op;
  logic [ADDR_W-1:0]         acc_addr;
  logic [DATA_W-1:0]         rd_now;
  logic [DATA_W-1:0]         rd_s1;
  logic                      mem_we;
  logic [ADDR_W-1:0]         mem_wa;
  logic [ssc_pkg::LANES-1:0] mem_be;

  // asynchronous pins pass the three-stage filter
  ssc_sync3 #(
    .W   (4),
    .RST (ssc_pkg::ASYNC_RST)
  ) u_sync (
    .core_clk (core_clk),
    .nrst     (nrst),
    .d        ({out_en_n, sleep_request, burst_order_select, flowthru_select_n}),
    .q        (async_s)
  );

  // filtered asynchronous controls
  assign g_n_s   = async_s[3];
  assign slp_s   = async_s[2];
  assign order_s = async_s[1];
  assign ft_s    = !async_s[0]; // low picks flow-through

  // next-state logic for the whole core
  always_comb begin
    n        = q;
    mem_we   = 1'b0;
    mem_wa   = q.s2_addr;
    mem_be   = q.s2_be;
    sel      = !chip_sel_low_first && chip_sel_high && !chip_sel_low_third;
    go       = !clk_gate_n && !slp_s && !q.asleep;
    nxt_cnt  = 2'(q.cnt + 2'h1); // two-bit wrap after four steps
    be_now   = ~{lane_four_wr_n, lane_three_wr_n, lane_two_wr_n, lane_one_wr_n};
    // command decode for this edge
    if (count_or_load) begin
      cur_op   = q.last_op; // deselect stays deselect else repeat
      acc_addr = {q.hi, burst_low(q.base, nxt_cnt, order_s)};
    end else if (!sel) begin
      cur_op   = ssc_pkg::OP_DESEL;
      acc_addr = addr;
    end else begin
      cur_op   = wr_n ? ssc_pkg::OP_READ : ssc_pkg::OP_WRITE;
      acc_addr = addr;
    end
    rd_now = mem_q[acc_addr];
    rd_s1  = mem_q[q.s1_addr];
    if (go) begin
      n.last_op = cur_op;
      if (count_or_load) begin
        if (q.last_op != ssc_pkg::OP_DESEL) begin
          n.cnt = nxt_cnt;
        end
      end else begin
        n.hi   = addr[ADDR_W-1:2]; // fresh address latched
        n.base = addr[1:0];
        n.cnt  = '0;
      end
      // command pipeline: stage one is last edge, stage two the one before
      n.s1_op   = cur_op;
      n.s1_addr = acc_addr;
      n.s1_be   = be_now; // lanes follow the current cycle
      n.s2_op   = q.s1_op;
      n.s2_addr = q.s1_addr;
      n.s2_be   = q.s1_be;
      if (ft_s) begin
        // single-late write: data taken one edge after the command
        if (q.s1_op == ssc_pkg::OP_WRITE && q.s1_be != '0) begin
          mem_we = 1'b1;
          mem_wa = q.s1_addr;
          mem_be = q.s1_be;
        end
        // read data leaves on the command edge itself
        n.drive = (cur_op == ssc_pkg::OP_READ); // writes turn drivers off
        if (cur_op == ssc_pkg::OP_READ) begin
          n.dq_o = rd_now;
        end
      end else begin
        // double-late write: data taken two edges after the command
        if (q.s2_op == ssc_pkg::OP_WRITE && q.s2_be != '0) begin
          mem_we = 1'b1; // empty lane set is an abort
        end
        // output register loads on the edge after the read
        n.drive = (q.s1_op == ssc_pkg::OP_READ);
        if (q.s1_op == ssc_pkg::OP_READ) begin
          n.dq_o = rd_s1;
        end
      end
    end
    // sleep sequencer; stalled state is kept while asleep
    if (slp_s && !q.asleep) begin
      n.scnt = 2'(q.scnt + 2'h1);
      if (q.scnt == 2'(ssc_pkg::SLEEP_ENTRY_CYC - 2'h1)) begin
        n.asleep = 1'b1;
        n.scnt   = '0;
      end
    end else if (!slp_s && q.asleep) begin
      n.scnt = 2'(q.scnt + 2'h1);
      if (q.scnt == 2'(ssc_pkg::SLEEP_EXIT_CYC - 2'h1)) begin
        n.asleep = 1'b0;
        n.scnt   = '0;
      end
    end else begin
      n.scnt = '0;
    end
    // pin drive: held through a stall gated by output enable
    n.oe = n.drive && !g_n_s && !slp_s && !n.asleep;
  end

  // state register; outputs high-Z from reset on
  always_ff @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      q <= ST_RST;
    end else begin
      q <= n;
    end
  end

  // storage array, written lane by lane with the late data
  always_ff @(posedge core_clk) begin
    if (mem_we) begin
      for (int i = 0; i < ssc_pkg::LANES; i++) begin
        if (mem_be[i]) begin
          mem_q[mem_wa][i*ssc_pkg::LANE_W +: ssc_pkg::LANE_W] <=
            dq_i[i*ssc_pkg::LANE_W +: ssc_pkg::LANE_W];
        end
      end
    end
  end

  // registered outputs
  assign dq_o        = q.dq_o;
  assign dq_oe       = q.oe;
  assign sleep_state = q.asleep;

  // checks on the core's own behaviour
  default clocking ast_cb @(posedge core_clk); endclocking
  default disable iff (!nrst);

  AST_STALL_HOLD: assert property (
    clk_gate_n |=> $stable(q.cnt) && $stable(q.last_op) && $stable(q.s1_op)
                   && $stable(q.drive)
  ) else $error("state moved during a gated edge");

  AST_DESELECT: assert property (
    go && !count_or_load && !sel
    |=> q.last_op == ssc_pkg::OP_DESEL && q.s1_op == ssc_pkg::OP_DESEL
        && ($past(!ft_s) || !q.drive)
  ) else $error("unselected load cycle not a deselect");

  AST_READ_START: assert property (
    go && !count_or_load && sel && wr_n
    |=> q.last_op == ssc_pkg::OP_READ && q.hi == $past(addr[ADDR_W-1:2])
        && q.base == $past(addr[1:0]) && q.cnt == 2'h0
  ) else $error("read start did not latch the address");

  AST_PL_LATENCY: assert property (
    (go && !ft_s && cur_op == ssc_pkg::OP_READ) ##1 (go && !ft_s)
    |=> q.drive && q.dq_o == $past(rd_s1)
  ) else $error("pipeline read data not loaded one edge later");

  AST_PL_EARLY: assert property (
    go && !ft_s && q.s1_op != ssc_pkg::OP_READ |=> !q.drive
  ) else $error("pipeline output drove without a registered read");

  AST_FT_LATENCY: assert property (
    go && ft_s && cur_op == ssc_pkg::OP_READ |=> q.drive && q.dq_o == $past(rd_now)
  ) else $error("flow-through read data not out after address edge");

  AST_PL_WRITE: assert property (
    (go && !ft_s && cur_op == ssc_pkg::OP_WRITE && be_now != '0)
    ##1 go ##1 (go && !ft_s) |-> mem_we && mem_wa == $past(acc_addr, 2)
  ) else $error("double-late write not committed at the third edge");

  AST_FT_WRITE: assert property (
    (go && ft_s && cur_op == ssc_pkg::OP_WRITE && be_now != '0)
    ##1 (go && ft_s) |-> mem_we && mem_wa == $past(acc_addr)
  ) else $error("single-late write not committed at the second edge");

  AST_WRITE_HIZ: assert property (
    go && ft_s && cur_op == ssc_pkg::OP_WRITE |=> !dq_oe
  ) else $error("drivers on during a write cycle");

  AST_ABORT: assert property (
    mem_we |-> mem_be != '0 && go
  ) else $error("write with no lanes or on a stalled edge");

  AST_OE_OFF: assert property (
    g_n_s |=> !dq_oe
  ) else $error("output enable off but pins driven");

  AST_CNT_STEP: assert property (
    go && count_or_load && q.last_op != ssc_pkg::OP_DESEL
    |=> q.cnt == 2'($past(q.cnt) + 2'h1) && $stable(q.hi) && $stable(q.base)
  ) else $error("burst counter did not step on a continue");

  AST_DESEL_CONT: assert property (
    go && count_or_load && q.last_op == ssc_pkg::OP_DESEL
    |=> q.last_op == ssc_pkg::OP_DESEL && !dq_oe
  ) else $error("continue after deselect left the deselect state");

  AST_SLEEP_ENTRY: assert property (
    slp_s && !q.asleep && q.scnt == 2'h0 ##1 slp_s |=> q.asleep
  ) else $error("sleep not entered two cycles after request");

  AST_SLEEP_HIZ: assert property (
    slp_s |=> !dq_oe
  ) else $error("bus driven while sleep requested");

endmodule

// file: rtl/ssc_sync3.sv
/*
  three-stage input filter for asynchronous control pins.
  assumes the pins are quasi-static; a change counts once stages two and
  three agree, so a glitch shorter than a clock leaves the output alone.
*/
`timescale 1ns/1ns
module ssc_sync3 #(
  parameter int           W   = 4,
  parameter logic [W-1:0] RST = '0
) (
  // clock and reset
  input  wire logic         core_clk,
  input  wire logic         nrst,
  // pin side
  input  wire logic [W-1:0] d,
  // core side
  output logic      [W-1:0] q
);

  typedef struct packed {
    logic [W-1:0] s1;
    logic [W-1:0] s2;
    logic [W-1:0] s3;
    logic [W-1:0] val;
  } ssc_sync_s;

  ssc_sync_s st_q;
  ssc_sync_s st_d;

  // shift chain; only stages two and three feed the output
  always_comb begin
    st_d    = st_q;
    st_d.s1 = d;
    st_d.s2 = st_q.s1;
    st_d.s3 = st_q.s2;
    for (int i = 0; i < W; i++) begin
      if (st_q.s2[i] == st_q.s3[i]) begin
        st_d.val[i] = st_q.s3[i];
      end
    end
  end

  // state register
  always_ff @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      st_q <= '{s1: RST, s2: RST, s3: RST, val: RST};
    end else begin
      st_q <= st_d;
    end
  end

  assign q = st_q.val;

endmodule
